//--- bench/tape_drive_model.sv
`timescale 1ns/1ps
// A rewind holds the selected drive not ready for 40 clocks
module tape_drive_model (
	input wire logic clk_i,
	input wire logic online_i,
	input wire tape_seq_pkg::drive_out_t drive_o_i,
	output tape_seq_pkg::drive_in_t drive_i_o
);
	logic [5:0] busy = '0;
	logic rew_d = 1'h0;
	logic back = 1'h0;
	// Direction is remembered while tape moves
	always @(posedge clk_i) begin
		rew_d <= drive_o_i.rewind;
		if (drive_o_i.rewind && !rew_d) busy <= 6'h28;
		else if (busy != 6'h0) busy <= busy - 6'h1;
		if (drive_o_i.go) back <= drive_o_i.backward;
	end
	assign drive_i_o = {~(16'(busy != 6'h0) << drive_o_i.select), busy != 6'h0, online_i, back};
endmodule

//--- bench/tape_seq_props.sv
`timescale 1ns/1ps
module tape_seq_props (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	input wire tape_seq_pkg::chan_in_t chan_i,
	input wire tape_seq_pkg::chan_out_t chan_o,
	input wire tape_seq_pkg::drive_in_t drive_i,
	input wire tape_seq_pkg::drive_out_t drive_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!arst_n_i);
	// Channel silent and drive online across the sync depth
	sequence calm;
		(chan_i[9:8] == 2'h0 && drive_i.select_ready) [*3];
	endsequence
	chk_rd_quiet: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
		else $error("stray rdata");
	chk_tag_single: assert property ($onehot0(chan_o[10:8]))
		else $error("two tags");
	chk_req_idle: assert property (chan_o.request_in |-> chan_o[10:8] == 3'h0)
		else $error("busy request");
	chk_addr_hold: assert property (calm ##0 chan_o.address_in |=> chan_o.address_in)
		else $error("address lost");
	chk_stat_hold: assert property (calm ##0 chan_o.status_in |=> chan_o.status_in)
		else $error("status lost");
	chk_drop_halt: assert property ($fell(drive_i.select_ready) |-> ##[1:6] !drive_o.go)
		else $error("go kept");
	chk_set_dir: assert property (!(drive_o.set_forward && drive_o.set_backward))
		else $error("two directions");
	chk_settle_hold: assert property ($rose(drive_o.set_read) |-> drive_o.set_read [*8])
		else $error("short settle");
endmodule

bind tape_channel_sequencer tape_seq_props props (.clk_i, .arst_n_i, .rd_i, .rdata_o,
	.chan_i, .chan_o, .drive_i, .drive_o);

//--- bench/tb.sv
`timescale 1ns/1ps
module tb;
	import tape_seq_pkg::*;
	logic clk_i = 0, arst_n_i = 0, wr = 0, rd = 0, ext = 0, on = 1;
	logic [5:0] addr = '0;
	logic [31:0] wdata = '0, rdata, rv;
	chan_in_t ci = '0;
	chan_out_t co;
	drive_in_t di;
	drive_out_t dv;
	int mismatches = 0, checked = 0;
	tape_channel_sequencer #(.FWD_PRELOAD(4)) DUT (.clk_i, .arst_n_i, .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .chan_i(ci),
		.chan_o(co), .drive_i(di), .drive_o(dv), .ext_sense_i(ext));
	tape_drive_model drives (.clk_i, .online_i(on), .drive_o_i(dv), .drive_i_o(di));
	initial forever #10 clk_i = ~clk_i;
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	// Register port: strobe for one cycle, then one free cycle
	task wreg(input logic [5:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clk_i) wr <= 1'h0;
		@(posedge clk_i);
	endtask
	task rreg(input logic [5:0] a);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk_i) rd <= 1'h0;
		@(posedge clk_i) rv = rdata;
	endtask
	// Tags: wait on an inbound one, or hold an outbound one until answered
	task wt(input int b, input logic v);
		int n;
		n = 0;
		while (co[b] !== v && n < 4000) begin
			@(posedge clk_i);
			n++;
		end
		chk(co[b], v);
	endtask
	task pl(input int t, input int b);
		ci[t] <= 1'h1;
		wt(b, 1'h0);
		ci[t] <= 1'h0;
		@(posedge clk_i);
	endtask
	// Data service cycle: service_in stays up, so pace by cycles
	task svc_pulse(input logic [7:0] d);
		ci.bus_out <= d;
		ci.service_out <= 1'h1;
		repeat (4) @(posedge clk_i);
		ci.service_out <= 1'h0;
		repeat (4) @(posedge clk_i);
	endtask
	task t_regs;
		rreg(REG_MODEL);
		chk(rv, 32'h1);
		rreg(6'h3F);
		chk(rv, 32'h0);
		$display("regs done");
	endtask
	task present(input logic stack, input logic de);
		wt(11, 1'h1);
		ci.select_out <= 1'h1;
		wt(10, 1'h1);
		chk(co.bus_in, 8'h09);
		pl(9, 10);
		wt(9, 1'h1);
		chk(co.bus_in[2], de);
		ci.select_out <= 1'h0;
		pl(stack ? 9 : 8, 9);
	endtask
	task t_present;
		wreg(REG_CMD, 32'hE9);
		repeat (60) @(posedge clk_i);
		if (co.status_in === 1'h1) pl(8, 9);
		chk({dv.select, dv.rewind}, 5'h13);
		present(1'h1, 1'h1);
		present(1'h0, 1'h0);
		present(1'h0, 1'h1);
		rreg(REG_DONE);
		chk(rv[9], 1'h0);
		$display("present done");
	endtask
	task t_write;
		int n;
		n = 0;
		wreg(REG_CMD, 32'h92);
		rreg(REG_FLAGS);
		chk(rv[4], 1'h0);
		wt(9, 1'h1);
		pl(8, 9);
		wt(8, 1'h1);
		pl(9, 8);
		rreg(REG_FLAGS);
		chk(rv[0], 1'h1);
		// Full prefetch: status cycle, then three data bytes
		wreg(REG_CMD, 32'h92);
		pl(8, 9);
		for (int k = 0; k < 3; k++) svc_pulse(8'h51 + 8'(k));
		while (dv.go !== 1'h1 && n < 4000) begin
			@(posedge clk_i);
			n++;
		end
		chk(dv.go, 1'h1);
		rreg(REG_PATH);
		chk(rv, 32'h00535251);
		wreg(REG_CMD, 32'h80);
		chk(dv.go, 1'h0);
		$display("write done");
	endtask
	task t_sense;
		for (int i = 0; i < SENSE_BYTES; i++) wreg(REG_SENSE + 6'(i), 32'hA0 + i);
		for (int s = 0; s < 2; s++) begin
			ext <= s[0];
			repeat (4) @(posedge clk_i);
			wreg(REG_CMD, 32'hD0);
			for (int k = 0; k < (s ? 24 : 6); k++) begin
				wt(8, 1'h1);
				chk(co.bus_in, 32'hA0 + k);
				svc_pulse(8'h00);
			end
			wt(9, 1'h1);
			pl(8, 9);
		end
		$display("sense done");
	endtask
	task t_motion;
		int n;
		int s;
		n = 0;
		s = 0;
		wreg(REG_CMD, 32'hB3);
		while (dv.go !== 1'h1 && n < 4000) begin
			if (co.status_in === 1'h1) pl(8, 9);
			else @(posedge clk_i);
			if (dv.set_read === 1'h1) s++;
			n++;
		end
		chk({dv.go, dv.backward}, 2'h2);
		chk(s >= 1260 && s <= 1300, 1'h1);
		on <= 1'h0;
		repeat (8) @(posedge clk_i);
		chk(dv.go, 1'h0);
		$display("motion done");
	endtask
	task print_verdict;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk_i);
		arst_n_i <= 1'h1;
		@(posedge clk_i);
		t_regs;
		t_present;
		t_write;
		t_sense;
		t_motion;
		print_verdict;
	end
	// Cut a hang short well past the expected run
	initial begin
		#1000000;
		mismatches++;
		print_verdict;
	end
endmodule

//--- hw/cell_paced_timer.sv
`timescale 1ns/1ps
module cell_paced_timer #(
	parameter int W = 16
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic load_i,
	input wire logic [W-1:0] load_value_i,
	input wire tape_seq_pkg::timer_mode_t mode_i,
	input wire logic dec_i,
	input wire logic rom_tick_i,
	input wire logic [7:0] cell_reload_i,
	output logic [W-1:0] count_o,
	output logic zero_o
);
	import tape_seq_pkg::*;

	// ************************************************************
	// Counters
	// ************************************************************
	logic [W-1:0] general_down_counter;
	logic [7:0] cell_period_counter;
	logic cell_zero;
	logic step;

	if (W < 16) begin : g_bad_width
		$error("counter too narrow for turnaround preloads");
	end

	// Decrement sources: microcode step, cycle pace or cell expiry
	assign cell_zero = (cell_period_counter == 8'h00);
	assign step = dec_i | ((mode_i == TM_ROM) & rom_tick_i) | ((mode_i == TM_CELL) & cell_zero);
	assign count_o = general_down_counter;
	assign zero_o = (general_down_counter == '0);

	// Cell counter reloads on expiry, general counter drops by one
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			general_down_counter <= '0;
			cell_period_counter <= 8'h00;
		end else if (load_i) begin
			general_down_counter <= load_value_i;
			cell_period_counter <= cell_reload_i;
		end else begin
			if (step && !zero_o) begin
				general_down_counter <= general_down_counter - 1'b1;
			end
			if (mode_i == TM_CELL) begin
				cell_period_counter <= cell_zero ? cell_reload_i : cell_period_counter - 8'h01;
			end
		end
	end
endmodule

//--- hw/tape_channel_sequencer.sv
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
// How it works
// - Service pending: request, select, no address
// - Undeliverable status sets pending, raises request
// - Address, command rise and fall, then status
// - Pending presentation uses stored drive address
// - Per-drive completion latch armed by busy
// - Rewind busy; not-ready fall sets completion
// - Any completion pending raises request
// - Scan counter from 15 for matching drive
// - Address with forced device end, then status
// - First service cycle no data, second data
// - Three bytes fetched before tape motion
// - Command instead of data sets zero-count fault
// - Counter value selects presented sense byte
// - Without strap only six sense bytes
// - Go, backward, rewind latches steer drive
// - Sample last direction, turnaround on reversal
// - Same direction settle: 40 hex cycles
// - Cell counter paces general counter
// - Turnaround: stop delay, then settle delay
// - Write then backward: five ms forward
// - Turnaround preloads chosen per drive model
// - Select-ready drop forces address zero
// - Final flag marks ending versus initial status
module tape_channel_sequencer #(
	parameter int GPC_W = 16,
	parameter int FWD_PRELOAD = tape_seq_pkg::FWD_PRELOAD_DEF
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic [5:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire tape_seq_pkg::chan_in_t chan_i,
	output tape_seq_pkg::chan_out_t chan_o,
	input wire tape_seq_pkg::drive_in_t drive_i,
	output tape_seq_pkg::drive_out_t drive_o,
	input wire logic ext_sense_i
);
	import tape_seq_pkg::*;

	if (GPC_W < 16 || FWD_PRELOAD < 1 || FWD_PRELOAD >= (1 << GPC_W)) begin : g_bad_param
		$error("counter width or forward preload out of range");
	end

	// ************************************************************
	// Input synchronisers
	// ************************************************************
	localparam int SYNC_W = 32;
	logic [SYNC_W-1:0] raw;
	logic [SYNC_W-1:0] sync;
	chan_in_t cs;
	drive_in_t ds;
	logic ext_s;

	assign raw = {chan_i, drive_i, ext_sense_i};
	for (genvar gi = 0; gi < SYNC_W; gi++) begin : g_sync
		logic meta;
		logic stage;
		// Two flops per pin bit
		always_ff @(posedge clk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				meta <= 1'b0;
				stage <= 1'b0;
			end else begin
				meta <= raw[gi];
				stage <= meta;
			end
		end
		assign sync[gi] = stage;
	end
	assign cs = sync[31:20];
	assign ds = sync[19:1];
	assign ext_s = sync[0];

	// ************************************************************
	// Edge detection and cycle pacing
	// ************************************************************
	logic cmd_q;
	logic svc_q;
	logic nr_q;
	logic rdy_q;
	logic [15:0] ready_q;
	logic [4:0] div_cnt;
	logic rom_tick;

	// Previous values of synchronised levels
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cmd_q <= 1'b0;
			svc_q <= 1'b0;
			nr_q <= 1'b0;
			rdy_q <= 1'b0;
			ready_q <= 16'h0000;
		end else begin
			cmd_q <= cs.command_out;
			svc_q <= cs.service_out;
			nr_q <= ds.sel_not_ready;
			rdy_q <= ds.select_ready;
			ready_q <= ds.ready;
		end
	end

	// Microcode cycle enable
	assign rom_tick = (div_cnt == 5'(ROM_DIV - 1));
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			div_cnt <= 5'h00;
		end else begin
			div_cnt <= rom_tick ? 5'h00 : div_cnt + 5'h01;
		end
	end

	logic cmd_rise;
	logic svc_rise;
	logic nr_fall;
	logic sr_fall;
	assign cmd_rise = cs.command_out & ~cmd_q;
	assign svc_rise = cs.service_out & ~svc_q;
	assign nr_fall = nr_q & ~ds.sel_not_ready;
	assign sr_fall = rdy_q & ~ds.select_ready;

	// ************************************************************
	// Software registers
	// ************************************************************
	logic [7:0] status_byte;
	logic [7:0] cell_period_reload;
	logic [2:0] model;
	logic [7:0] sense_mem [SENSE_BYTES];
	logic sw_start;
	op_t sw_op;
	logic [3:0] sw_drive;
	logic clr_zcf;
	logic clr_drop;
	logic sense_wr;

	assign sw_start = wr_i & (addr_i == REG_CMD) & wdata_i[CMD_START_BIT];
	assign sw_op = op_t'(wdata_i[CMD_OP_LSB +: 3]);
	assign sw_drive = wdata_i[3:0];
	assign clr_zcf = wr_i & (addr_i == REG_FLAGS) & wdata_i[FLAG_ZCF_BIT];
	assign clr_drop = wr_i & (addr_i == REG_FLAGS) & wdata_i[FLAG_DROP_BIT];
	assign sense_wr = wr_i & addr_i[5] & (addr_i[4:0] < 5'(SENSE_BYTES));

	// Plain storage registers
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			status_byte <= STATUS_RST;
			cell_period_reload <= CELL_RELOAD_RST;
			model <= MODEL_RST;
			for (int i = 0; i < SENSE_BYTES; i++) begin
				sense_mem[i] <= 8'h00;
			end
		end else begin
			if (wr_i && addr_i == REG_STATUS) begin
				status_byte <= wdata_i[7:0];
			end
			if (wr_i && addr_i == REG_CELL) begin
				cell_period_reload <= wdata_i[7:0];
			end
			if (wr_i && addr_i == REG_MODEL) begin
				model <= wdata_i[2:0];
			end
			if (sense_wr) begin
				sense_mem[addr_i[4:0]] <= wdata_i[7:0];
			end
		end
	end

	// ************************************************************
	// Sequencer state
	// ************************************************************
	seq_state_t state, next_state;
	logic [3:0] drive_addr, next_drive;
	logic int_pend, next_int_pend;
	logic svc_pend, next_svc_pend;
	logic final_status, next_final;
	logic zero_count_fault, next_zcf;
	logic select_ready_drop;
	logic forced_de, next_forced;
	logic go, next_go;
	logic backward, next_backward;
	logic rewind, next_rewind;
	logic [3:0] set_lines, next_set_lines;
	logic write_fetch, next_wfetch;
	logic [1:0] fetch_cnt, next_fcnt;
	logic [7:0] data_path [3];
	logic sense_phase, next_phase;
	logic [7:0] bus_q, next_bus;
	logic cmd_bwd, next_cmd_bwd;
	logic cmd_write, next_cmd_write;
	logic last_write, next_last_write;
	timer_mode_t tmode, next_tmode;
	logic [15:0] busy;
	logic [15:0] completion_pending_latch;
	logic [15:0] completion_line;
	logic [15:0] done_clr;
	logic t_load, t_dec, arm, ack_done, capture;
	logic [GPC_W-1:0] t_value;
	logic [GPC_W-1:0] gcount;
	logic gzero;
	logic [31:0] pair;
	logic [3:0] set_value;
	logic [4:0] nxt_idx;
	logic sel_hit;
	logic request;
	logic sense_last;

	assign pair = turn_pair(model);
	assign set_value = {~cmd_write, cmd_write, ~cmd_bwd, cmd_bwd};
	assign nxt_idx = sense_index(sense_phase, 5'(gcount - 1'b1));
	assign sense_last = sense_phase ? (gcount == GPC_W'(1)) : gzero;
	assign request = (int_pend | (|completion_pending_latch)) & (state == ST_IDLE);
	assign sel_hit = request & cs.select_out & ~cs.address_out;

	cell_paced_timer #(.W(GPC_W)) u_timer (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.load_i(t_load),
		.load_value_i(t_value),
		.mode_i(tmode),
		.dec_i(t_dec),
		.rom_tick_i(rom_tick),
		.cell_reload_i(cell_period_reload),
		.count_o(gcount),
		.zero_o(gzero)
	);

	// Per-drive completion lines and latches
	for (genvar gd = 0; gd < DRIVES; gd++) begin : g_done
		assign completion_line[gd] = busy[gd] & (ds.ready[gd] & ~ready_q[gd]
			| nr_fall & (drive_addr == 4'(gd)));
	end
	assign done_clr = ack_done ? (16'h0001 << drive_addr) : 16'h0000;

	// Next state of the sequencer
	always_comb begin
		next_state = state;
		next_drive = drive_addr;
		next_int_pend = int_pend;
		next_svc_pend = svc_pend;
		next_final = final_status;
		next_zcf = zero_count_fault & ~clr_zcf;
		next_forced = forced_de;
		next_go = go;
		next_backward = backward;
		next_rewind = rewind;
		next_set_lines = set_lines;
		next_wfetch = write_fetch;
		next_fcnt = fetch_cnt;
		next_phase = sense_phase;
		next_bus = bus_q;
		next_cmd_bwd = cmd_bwd;
		next_cmd_write = cmd_write;
		next_last_write = last_write;
		next_tmode = tmode;
		t_load = 1'b0;
		t_value = '0;
		t_dec = 1'b0;
		arm = 1'b0;
		ack_done = 1'b0;
		capture = 1'b0;
		case (state)
			ST_IDLE: begin
				if (sel_hit) begin
					next_svc_pend = 1'b1;
					if (int_pend) begin
						next_bus = {4'h0, drive_addr};
						next_forced = 1'b0;
						next_state = ST_ADDR;
					end else begin
						t_load = 1'b1;
						t_value = GPC_W'(SCAN_PRELOAD);
						next_tmode = TM_HOLD;
						next_state = ST_SCAN;
					end
				end else if (sw_start) begin
					case (sw_op)
						OP_WRITE, OP_LWR: begin
							next_drive = sw_drive;
							arm = 1'b1;
							next_cmd_bwd = 1'b0;
							next_cmd_write = 1'b1;
							next_final = 1'b0;
							next_bus = status_byte;
							next_wfetch = 1'b0;
							next_fcnt = 2'h0;
							next_state = ST_PFST;
						end
						OP_READF, OP_READB: begin
							next_drive = sw_drive;
							arm = 1'b1;
							next_cmd_bwd = (sw_op == OP_READB);
							next_cmd_write = 1'b0;
							next_state = ST_DIR;
						end
						OP_SENSE: begin
							t_load = 1'b1;
							t_value = GPC_W'(SENSE_BASE_PRELOAD);
							next_tmode = TM_HOLD;
							next_phase = 1'b0;
							next_bus = sense_mem[0];
							next_state = ST_SENSE;
						end
						OP_REWIND, OP_UNLOAD: begin
							next_drive = sw_drive;
							arm = 1'b1;
							next_go = 1'b0;
							next_rewind = 1'b1;
						end
						default: begin
							next_go = 1'b0;
							next_rewind = 1'b0;
						end
					endcase
				end
			end
			ST_SCAN: begin
				if (completion_pending_latch[gcount[3:0]]) begin
					next_drive = gcount[3:0];
					next_bus = {4'h0, gcount[3:0]};
					next_forced = 1'b1;
					next_state = ST_ADDR;
				end else if (gzero) begin
					next_svc_pend = 1'b0;
					next_state = ST_IDLE;
				end else begin
					t_dec = 1'b1;
				end
			end
			ST_ADDR: begin
				if (cmd_rise) begin
					next_state = ST_CMDF;
				end
			end
			ST_CMDF: begin
				if (!cs.command_out) begin
					next_bus = status_byte | (forced_de ? DEVICE_END_MASK : 8'h00);
					next_final = 1'b1;
					next_state = ST_STAT;
				end
			end
			ST_STAT: begin
				if (svc_rise) begin
					next_int_pend = 1'b0;
					next_svc_pend = 1'b0;
					ack_done = forced_de;
					next_state = ST_IDLE;
				end else if (cmd_rise) begin
					next_int_pend = 1'b1;
					next_svc_pend = 1'b0;
					next_state = ST_IDLE;
				end
			end
			ST_PFST: begin
				if (svc_rise) begin
					next_state = ST_PFDAT;
				end else if (cmd_rise) begin
					next_int_pend = 1'b1;
					next_state = ST_IDLE;
				end
			end
			ST_PFDAT: begin
				if (svc_rise) begin
					capture = 1'b1;
					next_fcnt = 2'h1;
					next_wfetch = 1'b1;
					next_state = ST_FETCH;
				end else if (cmd_rise) begin
					next_zcf = 1'b1;
					next_state = ST_IDLE;
				end
			end
			ST_FETCH: begin
				if (svc_rise) begin
					capture = 1'b1;
					next_fcnt = 2'(fetch_cnt + 2'h1);
					if (fetch_cnt == 2'h2) begin
						next_state = ST_DIR;
					end
				end
			end
			ST_DIR: begin
				t_load = 1'b1;
				if (cmd_bwd != ds.backward_memory) begin
					if (last_write && cmd_bwd) begin
						next_go = 1'b1;
						next_backward = 1'b0;
						t_value = GPC_W'(FWD_PRELOAD);
						next_tmode = TM_ROM;
						next_state = ST_TFWD;
					end else begin
						next_go = 1'b0;
						t_value = GPC_W'(pair[31:16]);
						next_tmode = TM_CELL;
						next_state = ST_TSTOP;
					end
				end else begin
					next_set_lines = set_value;
					t_value = GPC_W'(SETTLE_PRELOAD);
					next_tmode = TM_ROM;
					next_state = ST_SETTLE;
				end
			end
			ST_TFWD: begin
				if (gzero) begin
					next_go = 1'b0;
					t_load = 1'b1;
					t_value = GPC_W'(pair[31:16]);
					next_tmode = TM_CELL;
					next_state = ST_TSTOP;
				end
			end
			ST_TSTOP: begin
				if (gzero) begin
					next_set_lines = set_value;
					next_backward = cmd_bwd;
					t_load = 1'b1;
					t_value = GPC_W'(pair[15:0]);
					next_state = ST_TSET;
				end
			end
			ST_TSET, ST_SETTLE: begin
				if (gzero) begin
					next_set_lines = 4'h0;
					next_go = 1'b1;
					next_backward = cmd_bwd;
					next_last_write = cmd_write;
					next_tmode = TM_HOLD;
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (sw_start && sw_op == OP_STOP) begin
					next_go = 1'b0;
					next_state = ST_IDLE;
				end
			end
			ST_SENSE: begin
				if (svc_rise) begin
					if (!sense_last) begin
						t_dec = 1'b1;
						next_bus = sense_mem[nxt_idx];
					end else if (!sense_phase && ext_s) begin
						t_load = 1'b1;
						t_value = GPC_W'(SENSE_EXT_PRELOAD);
						next_phase = 1'b1;
						next_bus = sense_mem[6];
					end else begin
						next_bus = status_byte;
						next_final = 1'b1;
						next_forced = 1'b0;
						next_state = ST_STAT;
					end
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		if (sr_fall) begin
			next_state = ST_IDLE;
			next_go = 1'b0;
			next_set_lines = 4'h0;
			next_tmode = TM_HOLD;
		end
	end

	// Sequencer flops
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= ST_IDLE;
			{drive_addr, int_pend, svc_pend, final_status, zero_count_fault} <= 8'h00;
			{forced_de, go, backward, rewind, set_lines, write_fetch} <= 9'h000;
			{fetch_cnt, sense_phase, bus_q, cmd_bwd, cmd_write, last_write} <= 14'h0000;
			tmode <= TM_HOLD;
		end else begin
			state <= next_state;
			{drive_addr, int_pend, svc_pend, final_status} <= {next_drive, next_int_pend,
				next_svc_pend, next_final};
			zero_count_fault <= next_zcf;
			{forced_de, go, backward, rewind} <= {next_forced, next_go, next_backward, next_rewind};
			{set_lines, write_fetch, fetch_cnt} <= {next_set_lines, next_wfetch, next_fcnt};
			{sense_phase, bus_q} <= {next_phase, next_bus};
			{cmd_bwd, cmd_write, last_write} <= {next_cmd_bwd, next_cmd_write, next_last_write};
			tmode <= next_tmode;
		end
	end

	// Busy arms completion; completion set wins over acknowledge
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			busy <= 16'h0000;
			completion_pending_latch <= 16'h0000;
			select_ready_drop <= 1'b0;
			data_path <= '{8'h00, 8'h00, 8'h00};
		end else begin
			busy <= (busy & ~completion_line) | (arm ? (16'h0001 << next_drive) : 16'h0000);
			completion_pending_latch <= (completion_pending_latch & ~done_clr) | completion_line;
			select_ready_drop <= (select_ready_drop & ~clr_drop) | sr_fall;
			if (capture) begin
				data_path[fetch_cnt] <= cs.bus_out;
			end
		end
	end

	// ************************************************************
	// Outputs and read-back
	// ************************************************************
	logic [31:0] rd_mux;

	assign chan_o.request_in = request;
	assign chan_o.address_in = (state == ST_ADDR);
	assign chan_o.status_in = (state == ST_STAT) | (state == ST_PFST);
	assign chan_o.service_in = (state == ST_PFDAT) | (state == ST_FETCH) | (state == ST_SENSE);
	assign chan_o.bus_in = bus_q;
	assign drive_o = {drive_addr, go, backward, rewind, set_lines};

	// Read selection, microcode address shown beside drive address
	assign rd_mux = (addr_i == REG_CMD) ? {20'h00000, state, 4'h0, drive_addr}
		: (addr_i == REG_STATUS) ? {24'h000000, status_byte}
		: (addr_i == REG_CELL) ? {24'h000000, cell_period_reload}
		: (addr_i == REG_MODEL) ? {29'h00000000, model}
		: (addr_i == REG_FLAGS) ? {23'h000000, rewind, backward, go, write_fetch,
			final_status, svc_pend, int_pend, select_ready_drop, zero_count_fault}
		: (addr_i == REG_DONE) ? {busy, completion_pending_latch}
		: (addr_i == REG_PATH) ? {8'h00, data_path[2], data_path[1], data_path[0]}
		: 32'h00000000;

	// Read data one cycle after the strobe, zero otherwise
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_o <= 32'h00000000;
		end else begin
			rdata_o <= rd_i ? rd_mux : 32'h00000000;
		end
	end
endmodule

//--- hw/tape_seq_pkg.sv
package tape_seq_pkg;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 20;
	localparam int ROM_CYCLE_NS = 400;
	localparam int ROM_DIV = (ROM_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_TIME_US = 24;
	localparam logic [15:0] SETTLE_PRELOAD = 16'h0040;
	localparam int FWD_TIME_US = 5000;
	localparam int FWD_PRELOAD_DEF = FWD_TIME_US * 1000 / ROM_CYCLE_NS;
	localparam logic [15:0] SCAN_PRELOAD = 16'h000F;
	localparam logic [15:0] SENSE_BASE_PRELOAD = 16'h0005;
	localparam logic [15:0] SENSE_EXT_PRELOAD = 16'h0012;
	localparam int SENSE_BYTES = 24;
	localparam int DRIVES = 16;

	// ************************************************************
	// Register map and fields
	// ************************************************************
	localparam logic [5:0] REG_CMD = 6'h00;
	localparam logic [5:0] REG_STATUS = 6'h01;
	localparam logic [5:0] REG_CELL = 6'h02;
	localparam logic [5:0] REG_MODEL = 6'h03;
	localparam logic [5:0] REG_FLAGS = 6'h04;
	localparam logic [5:0] REG_DONE = 6'h05;
	localparam logic [5:0] REG_PATH = 6'h06;
	localparam logic [5:0] REG_SENSE = 6'h20;
	localparam int CMD_START_BIT = 7;
	localparam int CMD_OP_LSB = 4;
	localparam int FLAG_ZCF_BIT = 0;
	localparam int FLAG_DROP_BIT = 1;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] DEVICE_END_MASK = 8'h04;
	localparam logic [7:0] CELL_RELOAD_RST = 8'h0F;
	localparam logic [2:0] MODEL_RST = 3'h1;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [2:0] {
		OP_STOP = 3'h0, OP_WRITE = 3'h1, OP_LWR = 3'h2, OP_READF = 3'h3,
		OP_READB = 3'h4, OP_SENSE = 3'h5, OP_REWIND = 3'h6, OP_UNLOAD = 3'h7
	} op_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0, ST_SCAN = 4'h1, ST_ADDR = 4'h3, ST_CMDF = 4'h2,
		ST_STAT = 4'h6, ST_PFST = 4'h7, ST_PFDAT = 4'h5, ST_FETCH = 4'h4,
		ST_DIR = 4'hC, ST_TFWD = 4'hD, ST_TSTOP = 4'hF, ST_TSET = 4'hE,
		ST_SETTLE = 4'hA, ST_RUN = 4'hB, ST_SENSE = 4'h8
	} seq_state_t;

	typedef enum logic [1:0] {TM_HOLD = 2'h0, TM_ROM = 2'h1, TM_CELL = 2'h2} timer_mode_t;

	typedef struct packed {
		logic select_out;
		logic address_out;
		logic command_out;
		logic service_out;
		logic [7:0] bus_out;
	} chan_in_t;

	typedef struct packed {
		logic request_in;
		logic address_in;
		logic status_in;
		logic service_in;
		logic [7:0] bus_in;
	} chan_out_t;

	typedef struct packed {
		logic [15:0] ready;
		logic sel_not_ready;
		logic select_ready;
		logic backward_memory;
	} drive_in_t;

	typedef struct packed {
		logic [3:0] select;
		logic go;
		logic backward;
		logic rewind;
		logic set_read;
		logic set_write;
		logic set_forward;
		logic set_backward;
	} drive_out_t;

	// Turnaround preload pair per drive model: {stop delay, settle delay}
	function automatic logic [31:0] turn_pair(input logic [2:0] model);
		case (model)
			3'h0: turn_pair = {16'h7000, 16'hB000};
			3'h1: turn_pair = {16'h4000, 16'h6000};
			3'h2: turn_pair = {16'h5000, 16'h5000};
			3'h3: turn_pair = {16'h5000, 16'h5000};
			3'h4: turn_pair = {16'h4000, 16'h6000};
			3'h5: turn_pair = {16'h9000, 16'hE000};
			default: turn_pair = {16'h4000, 16'h6000};
		endcase
	endfunction

	// Sense byte index for a counter value in each phase
	function automatic logic [4:0] sense_index(input logic phase, input logic [4:0] cnt);
		sense_index = phase ? 5'(5'd24 - cnt) : 5'(5'd5 - cnt);
	endfunction

endpackage
